// *** rtl/vcdb_gen.sv ***
/*
  Virtual core doorbell generator: register file over AHB-Lite, per-core
  doorbell settings, per-VM one-of-many settings and a scanning event issuer.
  Assumes residency, pending state and validity arrive as synchronous levels.
*/
// The placing of the registers and the AHB-Lite register port were left to the implementer.
module vcdb_gen #(
  parameter int NUM_VM = vcdb_pkg::NUM_VM,
  parameter int CORES_PER_VM = vcdb_pkg::CORES_PER_VM,
  parameter int INTERRUPT_IDENTIFIER_LIMIT = vcdb_pkg::INTERRUPT_IDENTIFIER_LIMIT,
  parameter bit LPI_SUPPORT = 1'b1,
  parameter bit OFN_SUPPORT = 1'b1,
  parameter bit SWERR_SUPPORT = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] core_valid,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] core_resident,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] tgt_pend,
  input wire logic [NUM_VM*CORES_PER_VM-1:0][vcdb_pkg::PRIO_W-1:0] tgt_prio,
  input wire vcdb_pkg::vcdb_nonres_t nonres,
  input wire logic [NUM_VM-1:0] vm_valid,
  input wire logic [NUM_VM-1:0] vm_resident_ofn,
  input wire logic [NUM_VM-1:0] ofn_pend,
  input wire logic [NUM_VM-1:0][vcdb_pkg::PRIO_W-1:0] ofn_prio,
  output vcdb_pkg::vcdb_event_t dbell
);
  localparam int N = NUM_VM * CORES_PER_VM;
  localparam int EW = $clog2(N);
  localparam int VW = (NUM_VM > 1) ? $clog2(NUM_VM) : 1;
  localparam int CW = EW - VW;
  localparam int PW = vcdb_pkg::PRIO_W;
  localparam int IW = vcdb_pkg::INTERRUPT_IDENTIFIER_W;
  localparam int FW = vcdb_pkg::ID_FIELD_W;

  // Whole block state in one packed struct. Per-core settings sit in
  // flat arrays indexed by vm*CORES_PER_VM+core. The one-of-many
  // settings are kept per VM. The delayed validity copies give the
  // rising-edge detect that clears settings when a core or VM is made
  // valid. Growing N costs flops linearly and scan latency linearly,
  // but the condition logic stays one copy, shared by the scan.
  typedef struct packed {
    logic [N-1:0] db_ok;
    logic [N-1:0] req;
    logic [N-1:0][PW-1:0] floor;
    logic [N-1:0][IW-1:0] interrupt_identifier;
    logic [N-1:0] core_valid_q;
    logic [NUM_VM-1:0] vm_en;
    logic [NUM_VM-1:0][CW-1:0] vm_tgt;
    logic [NUM_VM-1:0] vm_valid_q;
    logic [EW-1:0] sel_idx;
    logic sel_ok;
    logic [VW-1:0] vm_sel;
    logic vm_ok;
    logic [EW-1:0] scan;
    logic ap_wr;
    logic ap_rd;
    logic [4:0] ap_addr;
    logic [31:0] rdata;
    logic err_vld;
    logic [IW-1:0] err_interrupt_identifier;
    vcdb_pkg::vcdb_event_t evt;
  } vcdb_state_t;

  vcdb_state_t st_ff;
  vcdb_state_t nxt_st;
  logic fire;
  logic [VW-1:0] scan_vm;
  logic [CW-1:0] scan_core;
  logic ofn_cond;

  // Split a flat core index into its VM and core parts
  function automatic logic [VW-1:0] idx_vm(input logic [EW-1:0] idx);
    idx_vm = VW'(idx >> CW);
  endfunction

  function automatic logic [CW-1:0] idx_core(input logic [EW-1:0] idx);
    idx_core = idx[CW-1:0];
  endfunction

  // Identifier field in range for the given count
  function automatic logic id_in_range(input logic [FW-1:0] id, input int count);
    id_in_range = (32'(id) < count);
  endfunction

  // Register read mux; unmapped offsets read zero
  function automatic logic [31:0] read_reg(input vcdb_state_t s, input logic [4:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    unique case (a)
      vcdb_pkg::OFS_CORE_SEL: begin
        d[vcdb_pkg::SEL_CORE_LSB +: CW] = idx_core(s.sel_idx);
        d[vcdb_pkg::SEL_VM_LSB +: VW] = idx_vm(s.sel_idx);
      end
      vcdb_pkg::OFS_CORE_STAT: begin
        d[vcdb_pkg::STAT_IDLE_BIT] = 1'b1;
        d[vcdb_pkg::STAT_V_BIT] = s.sel_ok;
      end
      vcdb_pkg::OFS_CORE_DB: begin
        d[vcdb_pkg::DB_INTERRUPT_IDENTIFIER_LSB +: IW] = s.interrupt_identifier[s.sel_idx];
        d[vcdb_pkg::DB_FLOOR_LSB +: PW] = s.floor[s.sel_idx];
        d[vcdb_pkg::DB_OK_BIT] = s.db_ok[s.sel_idx];
        d[vcdb_pkg::DB_REQ_BIT] = s.req[s.sel_idx];
      end
      vcdb_pkg::OFS_VM_SEL: d[0 +: VW] = s.vm_sel;
      vcdb_pkg::OFS_VM_STAT: begin
        d[vcdb_pkg::STAT_IDLE_BIT] = 1'b1;
        d[vcdb_pkg::STAT_V_BIT] = s.vm_ok;
      end
      vcdb_pkg::OFS_VM_DB: begin
        d[vcdb_pkg::VMDB_EN_BIT] = s.vm_en[s.vm_sel];
        d[vcdb_pkg::VMDB_CORE_LSB +: CW] = s.vm_tgt[s.vm_sel];
      end
      vcdb_pkg::OFS_SWERR: begin
        d[vcdb_pkg::SWERR_V_BIT] = s.err_vld;
        d[vcdb_pkg::SWERR_ID_LSB +: IW] = s.err_interrupt_identifier;
      end
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Scan pointer split; one shared checker instead of N copies
  // trades latency for area, since only one core is looked at per cycle
  assign scan_vm = idx_vm(st_ff.scan);
  assign scan_core = idx_core(st_ff.scan);

  assign ofn_cond = OFN_SUPPORT && !vm_resident_ofn[scan_vm] && st_ff.vm_en[scan_vm]
                    && ofn_pend[scan_vm];

  // Condition check for the core under scan
  vcdb_check #(
    .PRIO_W(PW)
  ) u_check (
    .nonresident(!core_resident[st_ff.scan]),
    .settings_ok(st_ff.db_ok[st_ff.scan]),
    .requested(st_ff.req[st_ff.scan]),
    .floor(st_ff.floor[st_ff.scan]),
    .tgt_pend(tgt_pend[st_ff.scan]),
    .tgt_prio(tgt_prio[st_ff.scan]),
    .ofn_cond(ofn_cond),
    .is_ofn_target(st_ff.vm_tgt[scan_vm] == scan_core),
    .ofn_prio(ofn_prio[scan_vm]),
    .fire(fire)
  );

  // Next state
  always_comb begin
    logic [EW-1:0] wi;
    logic [VW-1:0] wv;
    logic unreach;
    wi = st_ff.sel_idx;
    wv = st_ff.vm_sel;
    unreach = 1'b0;
    nxt_st = st_ff;
    nxt_st.core_valid_q = core_valid;
    nxt_st.vm_valid_q = vm_valid;
    nxt_st.evt.vld = 1'b0;

    // fresh core holds no doorbell settings
    for (int i = 0; i < N; i++) begin
      if (core_valid[i] && !st_ff.core_valid_q[i]) begin
        nxt_st.db_ok[i] = 1'b0;
        nxt_st.req[i] = 1'b0;
        nxt_st.floor[i] = '0;
        nxt_st.interrupt_identifier[i] = '0;
      end
    end
    for (int v = 0; v < NUM_VM; v++) begin
      if (vm_valid[v] && !st_ff.vm_valid_q[v]) begin
        nxt_st.vm_en[v] = 1'b0;
      end
    end

    // lapsed conditions skipped
    // Conditions are only judged on the scan visit; a brief cause gone by then gives nothing
    // Round-robin scan bounds the issue latency to N cycles
    nxt_st.scan = (32'(st_ff.scan) == N - 1) ? '0 : EW'(st_ff.scan + 1'b1);
    if (fire) begin
      unreach = 32'(st_ff.interrupt_identifier[st_ff.scan]) >= INTERRUPT_IDENTIFIER_LIMIT;
      nxt_st.req[st_ff.scan] = 1'b0;
      if (unreach) begin
        if (SWERR_SUPPORT) begin
          nxt_st.err_vld = 1'b1;
          nxt_st.err_interrupt_identifier = st_ff.interrupt_identifier[st_ff.scan];
        end
      end else begin
        nxt_st.evt.vld = 1'b1;
        nxt_st.evt.set_edge = LPI_SUPPORT;
        nxt_st.evt.interrupt_identifier = st_ff.interrupt_identifier[st_ff.scan];
      end
    end

    if (nonres.vld && 32'(nonres.idx) < N) begin
      nxt_st.req[nonres.idx] = nonres.req;
      if (nonres.req) begin
        nxt_st.floor[nonres.idx] = nonres.floor;
      end
    end

    // AHB data phase: write applied, read captured
    nxt_st.ap_wr = 1'b0;
    nxt_st.ap_rd = 1'b0;
    if (st_ff.ap_rd) begin
      nxt_st.rdata = read_reg(st_ff, st_ff.ap_addr);
    end
    if (st_ff.ap_wr) begin
      unique case (st_ff.ap_addr)
        vcdb_pkg::OFS_CORE_SEL: begin
          // select core by VM and core id
          if (hwdata[vcdb_pkg::SEL_S_BIT]) begin
            wi = EW'((32'(hwdata[vcdb_pkg::SEL_VM_LSB +: FW]) << CW)
                 | 32'(hwdata[vcdb_pkg::SEL_CORE_LSB +: FW]));
            nxt_st.sel_idx = wi;
            nxt_st.sel_ok = id_in_range(hwdata[vcdb_pkg::SEL_VM_LSB +: FW], NUM_VM)
                            && id_in_range(hwdata[vcdb_pkg::SEL_CORE_LSB +: FW],
                                           CORES_PER_VM)
                            && core_valid[wi];
          end
        end
        vcdb_pkg::OFS_CORE_DB: begin
          nxt_st.sel_ok = core_valid[wi];
          if (core_valid[wi]) begin
            nxt_st.db_ok[wi] = 1'b1;
            nxt_st.req[wi] = hwdata[vcdb_pkg::DB_REQ_BIT];
            nxt_st.floor[wi] = hwdata[vcdb_pkg::DB_FLOOR_LSB +: PW];
            nxt_st.interrupt_identifier[wi] = hwdata[vcdb_pkg::DB_INTERRUPT_IDENTIFIER_LSB +: IW];
          end
        end
        vcdb_pkg::OFS_VM_SEL: begin
          wv = VW'(hwdata[0 +: FW]);
          nxt_st.vm_sel = wv;
          nxt_st.vm_ok = id_in_range(hwdata[0 +: FW], NUM_VM) && vm_valid[wv];
        end
        vcdb_pkg::OFS_VM_DB: begin
          nxt_st.vm_ok = vm_valid[wv];
          if (vm_valid[wv]) begin
            nxt_st.vm_en[wv] = hwdata[vcdb_pkg::VMDB_EN_BIT];
            nxt_st.vm_tgt[wv] = hwdata[vcdb_pkg::VMDB_CORE_LSB +: CW];
          end
        end
        vcdb_pkg::OFS_SWERR: begin
          // Write one clears; a new error this cycle wins
          if (hwdata[vcdb_pkg::SWERR_V_BIT] && !(fire && unreach && SWERR_SUPPORT)) begin
            nxt_st.err_vld = 1'b0;
          end
        end
        default: nxt_st.vm_ok = st_ff.vm_ok;
      endcase
    end

    // AHB address phase; reads take one wait state
    // The wait state lets the read mux come from flops, keeping hrdata registered
    if (hsel && hready && htrans[1]) begin
      nxt_st.ap_wr = hwrite;
      nxt_st.ap_rd = !hwrite;
      nxt_st.ap_addr = haddr[4:0] & 5'h1c;
      if (haddr[31:5] != 27'h0000000) begin
        nxt_st.ap_addr = 5'h1c;
      end
    end
  end

  // State register
  // Reset clears everything, so inputs already high at release look like
  // fresh validity and wipe settings once more; harmless, all are zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bus outputs; the response is always OKAY, errors go to the status register
  assign hreadyout = !st_ff.ap_rd;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign dbell = st_ff.evt;
endmodule

// *** rtl/vcdb_pkg.sv ***
/*
  Constants and carriers for the virtual core doorbell generator.
  Assumes a single 200 MHz clock and an AHB-Lite master reaching the registers.
*/
// Notes on behaviour
// - Doorbell only for non-resident core with valid settings, request, and a cause.
// - Causing priority must be greater than or equal to the priority floor.
// - Settings invalid at creation; valid after select plus doorbell register write.
// - With locality interrupts the event is a set-edge on a physical interrupt.
// - Doorbell identifier comes from the doorbell register identifier field.
// - Doorbell requested exactly when the request bit is one.
// - Issuing an event clears the request; no more events until re-requested.
// - Request bit follows latest of non-resident report or software write.
// - Non-resident report with request captures the priority floor, readable.
// - Once conditions hold, the event goes out within bounded cycles.
// - Conditions that lapse before issue may or may not give an event.
// - Unreachable identifier: no event, request cleared, software error recorded.
// - VM select reports idle and valid; valid updated on select or doorbell write.
// - VM doorbell register holds one-of-many enable and target core.
// - One-of-many conditions: supported, no resident enabled core, enabled, pending.
// - VM made valid resets its one-of-many doorbell enable.
// - Core select by VM and core identifiers with select bit; idle and valid.
// - Core becoming valid loses all doorbell settings.
package vcdb_pkg;

  localparam int NUM_VM = 2;
  localparam int CORES_PER_VM = 4;
  localparam int PRIO_W = 5;
  localparam int INTERRUPT_IDENTIFIER_W = 16;
  localparam int INTERRUPT_IDENTIFIER_LIMIT = 8192;

  // Register byte offsets
  localparam logic [4:0] OFS_CORE_SEL = 5'h00;
  localparam logic [4:0] OFS_CORE_STAT = 5'h04;
  localparam logic [4:0] OFS_CORE_DB = 5'h08;
  localparam logic [4:0] OFS_VM_SEL = 5'h0c;
  localparam logic [4:0] OFS_VM_STAT = 5'h10;
  localparam logic [4:0] OFS_VM_DB = 5'h14;
  localparam logic [4:0] OFS_SWERR = 5'h18;

  // Field positions
  localparam int SEL_CORE_LSB = 0;
  localparam int SEL_VM_LSB = 8;
  localparam int SEL_S_BIT = 31;
  localparam int STAT_IDLE_BIT = 0;
  localparam int STAT_V_BIT = 1;
  localparam int DB_INTERRUPT_IDENTIFIER_LSB = 0;
  localparam int DB_FLOOR_LSB = 16;
  localparam int DB_OK_BIT = 30;
  localparam int DB_REQ_BIT = 31;
  localparam int VMDB_EN_BIT = 0;
  localparam int VMDB_CORE_LSB = 8;
  localparam int SWERR_V_BIT = 0;
  localparam int SWERR_ID_LSB = 16;
  localparam int ID_FIELD_W = 8;

  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Non-resident report from a processor core
  typedef struct packed {
    logic vld;
    logic [$clog2(NUM_VM*CORES_PER_VM)-1:0] idx;
    logic req;
    logic [PRIO_W-1:0] floor;
  } vcdb_nonres_t;

  // Doorbell event towards the physical pending logic
  typedef struct packed {
    logic vld;
    logic set_edge;
    logic [INTERRUPT_IDENTIFIER_W-1:0] interrupt_identifier;
  } vcdb_event_t;

endpackage

// *** rtl/vcdb_check.sv ***
/*
  Doorbell condition check for one indexed virtual core.
  Assumes all inputs are stable levels for the element under test.
*/
module vcdb_check #(
  parameter int PRIO_W = vcdb_pkg::PRIO_W
) (
  input wire logic nonresident,
  input wire logic settings_ok,
  input wire logic requested,
  input wire logic [PRIO_W-1:0] floor,
  input wire logic tgt_pend,
  input wire logic [PRIO_W-1:0] tgt_prio,
  input wire logic ofn_cond,
  input wire logic is_ofn_target,
  input wire logic [PRIO_W-1:0] ofn_prio,
  output logic fire
);
  logic tgt_hit;
  logic ofn_hit;

  assign tgt_hit = tgt_pend && (tgt_prio >= floor);
  assign ofn_hit = ofn_cond && is_ofn_target && (ofn_prio >= floor);
  assign fire = nonresident && settings_ok && requested && (tgt_hit || ofn_hit);
endmodule

// *** sim/vcdb_gen_sva.sv ***
/*
  Port checker for vcdb_gen, bound into every instance.
  Assumes one clock and a single AHB-Lite master driving the inputs.
*/
module vcdb_gen_sva #(
  parameter int NUM_VM = 2,
  parameter int CORES_PER_VM = 4,
  parameter int INTERRUPT_IDENTIFIER_LIMIT = 8192
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] core_valid,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] core_resident,
  input wire logic [NUM_VM*CORES_PER_VM-1:0] tgt_pend,
  input wire logic [NUM_VM-1:0] ofn_pend,
  input wire vcdb_pkg::vcdb_event_t dbell
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait_one; !hreadyout |=> hreadyout; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state too long");
  property p_wait_cause; $fell(hreadyout) |-> $past(hsel && hready && htrans[1] && !hwrite);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without read");
  property p_rdata_hold; !$rose(hreadyout) |-> $stable(hrdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_edge; dbell.vld |-> dbell.set_edge; endproperty
  a_edge: assert property (p_edge) else $error("event not set-edge");
  property p_reach; dbell.vld |-> dbell.interrupt_identifier < INTERRUPT_IDENTIFIER_LIMIT; endproperty
  a_reach: assert property (p_reach) else $error("event to unreachable id");
  property p_id_hold; !dbell.vld |-> $stable(dbell.interrupt_identifier); endproperty
  a_id_hold: assert property (p_id_hold) else $error("id moved without event");
  property p_nonres; dbell.vld |-> |$past(core_valid & ~core_resident); endproperty
  a_nonres: assert property (p_nonres) else $error("event with all cores resident");
  property p_cause; dbell.vld |-> (|$past(tgt_pend)) || (|$past(ofn_pend)); endproperty
  a_cause: assert property (p_cause) else $error("event without pending cause");
endmodule

bind vcdb_gen vcdb_gen_sva #(.NUM_VM(NUM_VM), .CORES_PER_VM(CORES_PER_VM),
  .INTERRUPT_IDENTIFIER_LIMIT(INTERRUPT_IDENTIFIER_LIMIT)) i_vcdb_gen_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .core_valid(core_valid), .core_resident(core_resident),
  .tgt_pend(tgt_pend), .ofn_pend(ofn_pend), .dbell(dbell));

// *** sim/vcdb_cores.sv ***
/*
  Processor core model: residency levels and non-resident reports.
  Assumes the bench calls leave() right after a rising edge.
*/
module vcdb_cores (
  input wire logic hclk,
  output logic [7:0] core_resident,
  output vcdb_pkg::vcdb_nonres_t nonres
);
  // All cores start resident, no report pending
  initial begin
    core_resident = 8'hff;
    nonres = '0;
  end
  // One-cycle report; fields turn to junk afterwards so nothing leans on them
  task automatic leave(input logic [2:0] idx, input logic req, input logic [4:0] fl);
    @(posedge hclk);
    nonres <= '{1'b1, idx, req, fl};
    core_resident[idx] <= 1'b0;
    @(posedge hclk);
    nonres <= '{1'b0, ~idx, ~req, ~fl};
  endtask
endmodule

// *** sim/vcdb_gen_tb.sv ***
/*
  Testbench for vcdb_gen: AHB-Lite register tasks and doorbell scenarios.
  Assumes the core model vcdb_cores and the bound checker.
*/
module vcdb_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [7:0] core_valid, core_resident, tgt_pend;
  logic [7:0][4:0] tgt_prio;
  logic [1:0] vm_valid, vm_ofn, ofn_pend;
  logic [1:0][4:0] ofn_prio;
  logic [15:0] ev_id;
  vcdb_pkg::vcdb_nonres_t nonres;
  vcdb_pkg::vcdb_event_t dbell;
  int err_count = 0;
  int n_tests = 0;
  int ev_n = 0;

  vcdb_gen i_vcdb_gen (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_valid(core_valid),
    .core_resident(core_resident), .tgt_pend(tgt_pend), .tgt_prio(tgt_prio),
    .nonres(nonres), .vm_valid(vm_valid), .vm_resident_ofn(vm_ofn), .ofn_pend(ofn_pend),
    .ofn_prio(ofn_prio), .dbell(dbell));
  vcdb_cores i_vcdb_cores (.hclk(hclk), .core_resident(core_resident), .nonres(nonres));

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Count doorbell pulses and keep the last identifier
  always @(posedge hclk) begin
    if (dbell.vld === 1'b1) begin
      ev_n++;
      ev_id = dbell.interrupt_identifier;
    end
  end
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100us;
    err_count++;
    finish_test;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One single AHB transfer; the watchdog ends a stuck wait
  task automatic ahb(input logic w, input logic [4:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {27'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    ahb(1'b1, a, v);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(d, e);
  endtask
  // Give the scan more than one full pass, then count events
  task automatic ev(input int e);
    repeat (12) @(posedge hclk);
    chk(ev_n, e);
  endtask
  task automatic finish_test;
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_valid = 8'hff;
    tgt_pend = 8'h00;
    tgt_prio = '0;
    vm_valid = 2'h3;
    vm_ofn = 2'h0;
    ofn_pend = 2'h0;
    ofn_prio = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    wr(5'h1c, 32'hffff_ffff);
    rc(5'h1c, 32'h0);
    wr(5'h00, 32'h8000_0001);
    rc(5'h04, 32'h3);
    rc(5'h08, 32'h0);
    wr(5'h08, 32'h0000_0100);
    rc(5'h08, 32'h4000_0100);
    i_vcdb_cores.leave(3'h1, 1'b1, 5'h05);
    rc(5'h08, 32'hc005_0100);
    tgt_pend[1] <= 1'b1;
    tgt_prio[1] <= 5'h04;
    ev(0);
    tgt_prio[1] <= 5'h05;
    ev(1);
    chk(ev_id, 32'h100);
    rc(5'h08, 32'h4005_0100);
    ev(1);
    wr(5'h08, 32'h8005_0100);
    ev(2);
    wr(5'h08, 32'h8005_2000);
    ev(2);
    rc(5'h08, 32'h4005_2000);
    rc(5'h18, 32'h2000_0001);
    wr(5'h18, 32'h1);
    ahb(1'b0, 5'h18, 32'h0);
    chk(d & 32'h1, 32'h0);
    // Targeted cause gone; one-of-many path aims at core 1
    tgt_pend[1] <= 1'b0;
    wr(5'h0c, 32'h0);
    rc(5'h10, 32'h3);
    wr(5'h14, 32'h0000_0101);
    rc(5'h14, 32'h0000_0101);
    wr(5'h08, 32'h8005_0101);
    ofn_pend[0] <= 1'b1;
    ofn_prio[0] <= 5'h05;
    vm_ofn[0] <= 1'b1;
    ev(2);
    vm_ofn[0] <= 1'b0;
    ev(3);
    chk(ev_id, 32'h101);
    // Revalidation of the VM and of the core in the same cycle
    ofn_pend[0] <= 1'b0;
    vm_valid[0] <= 1'b0;
    core_valid[1] <= 1'b0;
    repeat (2) @(posedge hclk);
    vm_valid[0] <= 1'b1;
    core_valid[1] <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 5'h14, 32'h0);
    chk(d & 32'h1, 32'h0);
    rc(5'h08, 32'h0);
    wr(5'h08, 32'h8000_0100);
    i_vcdb_cores.leave(3'h1, 1'b0, 5'h1f);
    rc(5'h08, 32'h4000_0100);
    ev(3);
    finish_test;
  end
endmodule
